// *** adcsrp_regs.svh ***
// timing counts, word layout, clamp limits and reset values of the serial result port
`ifndef ADCSRP_REGS_SVH
`define ADCSRP_REGS_SVH

// system clock and device-driven serial clock timing
`define ADCSRP_CLK_PERIOD_NS   10
`define ADCSRP_SCK_HALF_NS     50
`define ADCSRP_SCK_HALF_CYC    ((`ADCSRP_SCK_HALF_NS + `ADCSRP_CLK_PERIOD_NS - 1) / `ADCSRP_CLK_PERIOD_NS)

// output word layout
`define ADCSRP_WORD_BITS       32
`define ADCSRP_PEND_BIT        31
`define ADCSRP_ZERO_BIT        30
`define ADCSRP_POL_BIT         29
`define ADCSRP_RES_MSB         28
`define ADCSRP_RES_LSB         5
`define ADCSRP_SUB_MSB         4
`define ADCSRP_RATE_BITS       5

// falling edge that enters data output, and the last falling edge of a frame
`define ADCSRP_FALL_ENTER      6'h05
`define ADCSRP_FALL_LAST       6'h20

// converter core value: signed, one sub-LSB per unit
`define ADCSRP_CORE_BITS       31
`define ADCSRP_POS_CLAMP       31'sh10000000
`define ADCSRP_NEG_CLAMP       (-31'sh10000001)
`define ADCSRP_OFFSET          31'sh20000000

// reset values
`define ADCSRP_RATE_RESET      5'h00

`endif

// *** adcsrp_pkg.sv ***
// types and rate decode shared by the serial result port
package adcsrp_pkg;

    // conversion cycle state
    typedef enum logic [0:0] {
        CONVERT = 1'b0,
        SLEEP   = 1'b1
    } adcsrp_state_type;

    // rate code to log2 of the oversampling ratio; the top code bit is ignored
    function automatic logic [3:0] ratioLog2(input logic [4:0] code);
        logic [3:0] res;
        res = 4'h8;
        case (code[3:0])
            4'h1:    res = 4'h6;
            4'h2:    res = 4'h7;
            4'h3:    res = 4'h8;
            4'h4:    res = 4'h9;
            4'h5:    res = 4'ha;
            4'h6:    res = 4'hb;
            4'h7:    res = 4'hc;
            4'h8:    res = 4'hd;
            4'h9:    res = 4'he;
            4'hf:    res = 4'hf;
            default: res = 4'h8;
        endcase
        return res;
    endfunction : ratioLog2

endpackage : adcsrp_pkg

// *** adcsrp_sync.sv ***
// two-flop level synchroniser, one chain per bit
`timescale 1ns/1ps
module adcsrp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // levels from another domain and their synchronised copy
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_r;

    // each bit passes two flip-flops; only the second reads the first
    generate
        for (genvar i = 0; i < WIDTH; i++)
        begin : gBit
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    stage1_r[i] <= 1'b0;
                    syncOut[i]  <= 1'b0;
                end
                else
                begin
                    stage1_r[i] <= asyncIn[i];
                    syncOut[i]  <= stage1_r[i];
                end
            end
        end
    endgenerate

endmodule : adcsrp_sync

// *** adcsrp_word_format.sv ***
// clamps a core value and builds the 32-bit output word
`timescale 1ns/1ps
`include "adcsrp_regs.svh"
module adcsrp_word_format (
    // signed core value, one unit per sub-LSB
    input  wire logic signed [`ADCSRP_CORE_BITS-1:0] coreValue,
    // formatted word with the pending flag low
    output logic             [`ADCSRP_WORD_BITS-1:0] word
);

    logic signed [`ADCSRP_CORE_BITS-1:0] clamped;
    logic signed [`ADCSRP_CORE_BITS-1:0] offsetVal;

    // clamp to full scale plus or minus one sub-LSB
    always_comb
    begin
        clamped = coreValue;
        if (coreValue > `ADCSRP_POS_CLAMP)
            clamped = `ADCSRP_POS_CLAMP;
        else if (coreValue < `ADCSRP_NEG_CLAMP)
            clamped = `ADCSRP_NEG_CLAMP;
    end

    // offset binary: polarity high for zero and up, 11 and 00 mark over and under range
    assign offsetVal = clamped + `ADCSRP_OFFSET;

    // pending low, filler zero, polarity, 24-bit result, five sub-LSBs
    assign word = {1'b0,
                   1'b0,
                   offsetVal[`ADCSRP_POL_BIT:0]};

endmodule : adcsrp_word_format

// *** adcsrp_port.sv ***
// serial result port: word formatting, serial shift-out, frame control, rate input
`timescale 1ns/1ps
`include "adcsrp_regs.svh"
module adcsrp_port #(
    parameter int SCK_HALF_CYC = `ADCSRP_SCK_HALF_CYC
) (
    // system clock, reset and clock enable
    input  wire logic                                clk,
    input  wire logic                                reset_n,
    input  wire logic                                ce,
    // serial link pins
    input  wire logic                                linkClk,
    input  wire logic                                csN,
    input  wire logic                                sdi,
    input  wire logic                                clockSourceSelect,
    output logic                                     sdoOut,
    output logic                                     sdoOe,
    output logic                                     sckOut,
    output logic                                     sckOe,
    // converter core side
    input  wire logic                                coreDone,
    input  wire logic signed [`ADCSRP_CORE_BITS-1:0] coreValue,
    output logic                                     convStart,
    output logic                                     busy,
    output logic             [`ADCSRP_RATE_BITS-1:0] oversamplingRatio,
    output logic             [3:0]                   ratioLog2
);

    // ---------------- declarations
    adcsrp_pkg::adcsrp_state_type state_r;
    adcsrp_pkg::adcsrp_state_type state_nxt;

    logic [`ADCSRP_WORD_BITS-1:0] wordNew;
    logic [`ADCSRP_WORD_BITS-1:0] wordHold_r;
    logic                         busy_r;
    logic                         convStart_r;
    logic [`ADCSRP_RATE_BITS-1:0] rateCode_r;

    // link domain
    logic                         linkRst_n;
    logic [5:0]                   fallCnt_r;
    logic [5:0]                   fallCnt_nxt;
    logic                         entered_r;
    logic                         doneTgl_r;
    logic [`ADCSRP_RATE_BITS-1:0] rateShift_r;

    // crossings into the system clock domain
    logic [3:0]                   syncIn;
    logic [3:0]                   syncOut;
    logic                         doneSync;
    logic                         enteredSync;
    logic                         csSync;
    logic                         clkSrcSync;
    logic                         doneSeen_r;
    logic                         enteredSeen_r;
    logic                         frameDone;
    logic                         frameAbort;
    logic                         frameEnd;

    // device clock generator
    logic                         genActive_r;
    logic                         genDone_r;
    logic [15:0]                  halfCnt_r;
    logic [5:0]                   genCnt_r;
    logic                         sckOut_r;
    logic                         sckOe_r;

    // serial data selection
    logic [4:0]                   bitSel;
    logic                         pendLevel;

    // ---------------- word formatter
    adcsrp_word_format uFormat (
        .coreValue (coreValue),
        .word      (wordNew)
    );

    // ---------------- synchronisers for link events and pin levels
    assign syncIn = {doneTgl_r, entered_r, csN, clockSourceSelect};

    adcsrp_sync #(
        .WIDTH (4)
    ) uSync (
        .clk     (clk),
        .reset_n (reset_n),
        .asyncIn (syncIn),
        .syncOut (syncOut)
    );

    assign doneSync    = syncOut[3];
    assign enteredSync = syncOut[2];
    assign csSync      = syncOut[1];
    assign clkSrcSync  = syncOut[0];

    // ================= link clock domain
    // select high clears the frame position; a rising select ends a frame only once data output was entered
    assign linkRst_n = reset_n & ~csN;

    // falling edge count wraps after 32 so a held-low select can read again
    always_comb
    begin
        fallCnt_nxt = fallCnt_r + 6'h01;
        if (fallCnt_r == `ADCSRP_FALL_LAST)
            fallCnt_nxt = 6'h01;
    end

    // falling edges step through the word
    always_ff @(negedge linkClk or negedge linkRst_n)
    begin
        if (!linkRst_n)
            fallCnt_r <= 6'h00;
        else
            fallCnt_r <= fallCnt_nxt;
    end

    // data output state entered from the fifth falling edge to the 31st, left on the last
    always_ff @(negedge linkClk or negedge linkRst_n)
    begin
        if (!linkRst_n)
            entered_r <= 1'b0;
        else
            entered_r <= (fallCnt_nxt >= `ADCSRP_FALL_ENTER) &&
                         (fallCnt_nxt < `ADCSRP_FALL_LAST);
    end

    // 32nd falling edge flags a completed frame; survives the select rising
    always_ff @(negedge linkClk or negedge reset_n)
    begin
        if (!reset_n)
            doneTgl_r <= 1'b0;
        else if (!csN && fallCnt_nxt == `ADCSRP_FALL_LAST)
            doneTgl_r <= ~doneTgl_r;
    end

    // rate code bits enter on the first five rising edges, top bit first
    always_ff @(posedge linkClk or negedge reset_n)
    begin
        if (!reset_n)
            rateShift_r <= `ADCSRP_RATE_RESET;
        else if (!csN && (fallCnt_r < `ADCSRP_FALL_ENTER || fallCnt_r == `ADCSRP_FALL_LAST))
            rateShift_r <= {rateShift_r[`ADCSRP_RATE_BITS-2:0], sdi};
    end

    // ================= serial data output
    // bit index after k falling edges is 31 - k
    assign bitSel = 5'h1f - fallCnt_r[4:0];

    // pending flag: converting, or a frame end not yet taken over by busy
    assign pendLevel = busy_r | (doneTgl_r ^ doneSeen_r);

    // before the first falling edge the live pending flag shows
    always_comb
    begin
        if (fallCnt_r == 6'h00 || fallCnt_r == `ADCSRP_FALL_LAST)
            sdoOut = pendLevel;
        else
            sdoOut = wordHold_r[bitSel];
    end

    // driver floats whenever select is high
    assign sdoOe = ~csN;

    // ================= system clock domain
    // frame completion and abort events
    assign frameDone  = doneSync ^ doneSeen_r;
    assign frameAbort = csSync & enteredSeen_r;
    assign frameEnd   = frameDone | frameAbort;

    // completion toggle follower
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            doneSeen_r <= 1'b0;
        else if (ce)
            doneSeen_r <= doneSync;
    end

    // remembers that data output was entered in this sleep period
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            enteredSeen_r <= 1'b0;
        else if (ce)
        begin
            if (state_r == adcsrp_pkg::CONVERT || frameEnd)
                enteredSeen_r <= 1'b0;
            else if (enteredSync)
                enteredSeen_r <= 1'b1;
        end
    end

    // conversion cycle next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            adcsrp_pkg::CONVERT:
                if (coreDone)
                    state_nxt = adcsrp_pkg::SLEEP;
            adcsrp_pkg::SLEEP:
                if (frameEnd)
                    state_nxt = adcsrp_pkg::CONVERT;
            default:
                state_nxt = adcsrp_pkg::CONVERT;
        endcase
    end

    // conversion cycle state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state_r <= adcsrp_pkg::CONVERT;
        else if (ce)
            state_r <= state_nxt;
    end

    // busy high from conversion start until the core reports done
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            busy_r <= 1'b1;
        else if (ce)
            busy_r <= (state_nxt == adcsrp_pkg::CONVERT);
    end

    // one-cycle start pulse to the core, also once after reset
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            convStart_r <= 1'b1;
        else if (ce)
            convStart_r <= (state_r == adcsrp_pkg::SLEEP) && frameEnd;
    end

    // result word loads only on the done strobe while converting
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            wordHold_r <= '0;
        else if (ce && state_r == adcsrp_pkg::CONVERT && coreDone)
            wordHold_r <= wordNew; // held through sleep
    end

    // rate code taken at conversion start; the link clock is stopped by then
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rateCode_r <= `ADCSRP_RATE_RESET;
        else if (ce && state_r == adcsrp_pkg::SLEEP && frameEnd)
            rateCode_r <= rateShift_r;
    end

    // ================= device-driven serial clock
    // pin drive follows the clock source select level
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sckOe_r <= 1'b0;
        else if (ce)
            sckOe_r <= clkSrcSync;
    end

    // one burst per sleep period, rearmed by the next conversion
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            genDone_r <= 1'b0;
        else if (ce)
        begin
            if (state_r == adcsrp_pkg::CONVERT)
                genDone_r <= 1'b0;
            else if (genActive_r && sckOut_r && halfCnt_r == 16'(SCK_HALF_CYC - 1)
                     && genCnt_r == `ADCSRP_FALL_LAST - 6'h01)
                genDone_r <= 1'b1;
        end
    end

    // burst runs in sleep with select low; select high stops it within four clock cycles
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            genActive_r <= 1'b0;
        else if (ce)
        begin
            if (csSync || !clkSrcSync || state_r != adcsrp_pkg::SLEEP)
                genActive_r <= 1'b0;
            else if (!genActive_r && !genDone_r)
                genActive_r <= 1'b1;
            else if (genActive_r && sckOut_r && halfCnt_r == 16'(SCK_HALF_CYC - 1)
                     && genCnt_r == `ADCSRP_FALL_LAST - 6'h01)
                genActive_r <= 1'b0; // exactly 32 pulses
        end
    end

    // half-period divider
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            halfCnt_r <= 16'h0000;
        else if (ce)
        begin
            if (!genActive_r || halfCnt_r == 16'(SCK_HALF_CYC - 1))
                halfCnt_r <= 16'h0000;
            else
                halfCnt_r <= halfCnt_r + 16'h0001;
        end
    end

    // serial clock level, idle low outside the burst
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sckOut_r <= 1'b0;
        else if (ce)
        begin
            if (!genActive_r)
                sckOut_r <= 1'b0;
            else if (halfCnt_r == 16'(SCK_HALF_CYC - 1))
                sckOut_r <= ~sckOut_r;
        end
    end

    // falling edges produced in this burst
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            genCnt_r <= 6'h00;
        else if (ce)
        begin
            if (!genActive_r)
                genCnt_r <= 6'h00;
            else if (sckOut_r && halfCnt_r == 16'(SCK_HALF_CYC - 1))
                genCnt_r <= genCnt_r + 6'h01;
        end
    end

    // ---------------- outputs
    assign sckOut            = sckOut_r;
    assign sckOe             = sckOe_r;
    assign convStart         = convStart_r;
    assign busy              = busy_r;
    assign oversamplingRatio = rateCode_r;
    assign ratioLog2         = adcsrp_pkg::ratioLog2(rateCode_r);

endmodule : adcsrp_port

// *** adcsrp_port_assertions.sv ***
// concurrent checks on the pins of the serial result port
`timescale 1ns/1ps
`include "adcsrp_regs.svh"
module adcsrp_port_assertions #(
    parameter int SCK_HALF_CYC = `ADCSRP_SCK_HALF_CYC
) (
    // clock, reset and enable
    input wire logic                                clk,
    input wire logic                                reset_n,
    input wire logic                                ce,
    // serial link pins
    input wire logic                                linkClk,
    input wire logic                                csN,
    input wire logic                                sdi,
    input wire logic                                clockSourceSelect,
    input wire logic                                sdoOut,
    input wire logic                                sdoOe,
    input wire logic                                sckOut,
    input wire logic                                sckOe,
    // converter core side
    input wire logic                                coreDone,
    input wire logic signed [`ADCSRP_CORE_BITS-1:0] coreValue,
    input wire logic                                convStart,
    input wire logic                                busy,
    input wire logic        [`ADCSRP_RATE_BITS-1:0] oversamplingRatio,
    input wire logic        [3:0]                   ratioLog2
);
    logic       sckPrev_r;
    logic [6:0] sckCnt_r;

    // previous level of the generated clock
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sckPrev_r <= 1'b0;
        else
            sckPrev_r <= sckOut;
    end

    // generated clock pulses since the last conversion ended
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sckCnt_r <= 7'h00;
        else if (busy)
            sckCnt_r <= 7'h00;
        else if (sckOut && !sckPrev_r)
            sckCnt_r <= sckCnt_r + 7'h01;
    end

    // start pulse lasting one cycle with busy held after it
    sequence startSeq;
        convStart ##1 (busy && !convStart);
    endsequence

    // core result taken while converting
    sequence doneSeq;
        coreDone && busy && ce;
    endsequence

    sdo_enable_a: assert property (@(posedge clk) disable iff (!reset_n)
        sdoOe == !csN) else $error("sdo enable differs from select");
    pend_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        busy && !csN |-> sdoOut) else $error("pending flag low while converting");
    start_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        convStart && $past(reset_n) |-> startSeq) // pulse held through reset is skipped
        else $error("start pulse or busy wrong");
    done_sleep_a: assert property (@(posedge clk) disable iff (!reset_n)
        doneSeq |=> !busy && (csN || !sdoOut)) else $error("completion not shown");
    sleep_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !busy && csN && $past(csN, 6) |=> !busy) else $error("sleep left without a read");
    sck_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        !sckOe |-> !sckOut) else $error("clock driven in host clock mode");
    sck_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        csN [*5] |-> !sckOut) else $error("clock runs while deselected");
    pulse_limit_a: assert property (@(posedge clk) disable iff (!reset_n)
        sckCnt_r <= 7'h20) else $error("more than 32 clock pulses");
    rate_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(oversamplingRatio) |-> busy || convStart) else $error("rate changed in sleep");
    rate_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
        oversamplingRatio == 5'h1f |-> ratioLog2 == 4'hf) else $error("top code decode wrong");
endmodule : adcsrp_port_assertions

bind adcsrp_port adcsrp_port_assertions #(.SCK_HALF_CYC(SCK_HALF_CYC)) chk_u (
    .clk(clk), .reset_n(reset_n), .ce(ce), .linkClk(linkClk), .csN(csN), .sdi(sdi),
    .clockSourceSelect(clockSourceSelect), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .sckOut(sckOut), .sckOe(sckOe), .coreDone(coreDone), .coreValue(coreValue),
    .convStart(convStart), .busy(busy), .oversamplingRatio(oversamplingRatio),
    .ratioLog2(ratioLog2));

// *** adcsrp_host_model.sv ***
// host serial master stand-in: select, host clock and rate code input
`timescale 1ns/1ps
module adcsrp_host_model (
    // link levels seen by the host
    input  wire logic sdoLine,
    input  wire logic sckLine,
    input  wire logic devClock,
    // link pins driven by the host
    output logic      hostSck,
    output logic      csN,
    output logic      sdi
);
    // idle: deselected, host clock parked low
    initial
    begin
        hostSck = 1'b0;
        csN     = 1'b1;
        sdi     = 1'b0;
    end

    // lower select without clocking
    task automatic select;
        csN = 1'b0;
    endtask : select

    // raise select; input line no longer holds its last value
    task automatic deselect;
        csN = 1'b1;
        sdi = ~sdi;
    endtask : deselect

    // nClk pulses, 6 ns on the host clock or paced by the device clock; code top bit first on the first five rises
    task automatic frame(input int nClk, input logic [4:0] code, output logic [31:0] word);
        word = 32'h0;
        csN  = 1'b0;
        if (!devClock)
            #20;
        for (int k = 0; k < nClk; k++)
        begin
            sdi = (k < 5) ? code[4 - k] : ~sdi;  // rate code
            if (devClock)
                @(posedge sckLine);             // device clock
            else
                #3 hostSck = 1'b1;              // host clock
            word[31 - k] = sdoLine;             // taken on rises
            if (devClock)
                @(negedge sckLine);
            else
                #3 hostSck = 1'b0;
        end
    endtask : frame
endmodule : adcsrp_host_model

// *** tb_top.sv ***
// self-checking bench: host frames, aborts and device clocked frames
`timescale 1ns/1ps
`include "adcsrp_regs.svh"
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); end end
module tb_top;
    // design pins and bench state
    logic                                clk;
    logic                                reset_n = 1'b0;
    logic                                ce = 1'b1;
    logic                                clockSourceSelect = 1'b0;
    logic                                coreDone = 1'b0;
    logic signed [`ADCSRP_CORE_BITS-1:0] coreValue = '0;
    logic signed [`ADCSRP_CORE_BITS-1:0] curVal = '0;
    logic                                sdoOut, sdoOe, sckOut, sckOe, convStart, busy;
    logic        [`ADCSRP_RATE_BITS-1:0] oversamplingRatio;
    logic        [3:0]                   ratioLog2;
    logic                                hostSck, csN, sdi;
    wire                                 sdoLine, sckLine;
    logic        [31:0]                  word;
    int                                  err_count = 0, check_count = 0, cycles = 0;
    int                                  convCnt = 0, sckPulses = 0;
    // per frame: core value, expected word, rate code, decoded ratio
    logic signed [`ADCSRP_CORE_BITS-1:0] vals [7] = '{31'sh0, -31'sh1, 31'sh10000000,
        31'sh10000005, -31'sh10000000, -31'sh10000007, 31'sh0abcdef1};
    logic [31:0] expw [7] = '{32'h20000000, 32'h1fffffff, 32'h30000000, 32'h30000000,
        32'h10000000, 32'h0fffffff, 32'h2abcdef1};
    logic [4:0]  codes [7] = '{5'h00, 5'h1f, 5'h01, 5'h07, 5'h10, 5'h09, 5'h03};
    logic [3:0]  logs [7] = '{4'h8, 4'hf, 4'h6, 4'hc, 4'h8, 4'he, 4'h8};

    // resolved link lines
    assign sdoLine = sdoOe ? sdoOut : 1'bz;
    assign sckLine = sckOe ? sckOut : hostSck;

    adcsrp_port #(.SCK_HALF_CYC(1)) dut_u (
        .clk(clk), .reset_n(reset_n), .ce(ce), .linkClk(sckLine), .csN(csN), .sdi(sdi),
        .clockSourceSelect(clockSourceSelect), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .sckOut(sckOut), .sckOe(sckOe), .coreDone(coreDone), .coreValue(coreValue),
        .convStart(convStart), .busy(busy), .oversamplingRatio(oversamplingRatio),
        .ratioLog2(ratioLog2));

    adcsrp_host_model host_u (.sdoLine(sdoLine), .sckLine(sckLine),
        .devClock(clockSourceSelect), .hostSck(hostSck), .csN(csN), .sdi(sdi));

    // 100 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // converter stand-in: done pulse 20 cycles after each start
    always @(posedge clk)
    begin
        coreDone <= 1'b0;
        if (convStart)
            convCnt <= 20;
        else if (convCnt > 0)
            convCnt <= convCnt - 1;
        if (convCnt == 1 && !convStart)
        begin
            coreDone  <= 1'b1;
            coreValue <= curVal;
        end
    end

    // hang guard and generated clock pulse count
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            test_done();
        end
    end
    always @(posedge sckOut) sckPulses++;

    // bounded wait for the end of a conversion
    task automatic waitIdle;
        for (int n = 0; n < 300 && busy !== 1'b0; n++)
            @(posedge clk);
        @(posedge clk);
    endtask : waitIdle

    // counts, verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        `CHK("busy in reset", 1'b1, busy)             // busy
        `CHK("rate in reset", 5'h00, oversamplingRatio) // rate
        `CHK("ratio in reset", 4'h8, ratioLog2)       // ratio
        `CHK("sck in reset", 1'b0, sckOut)            // idle clock
        reset_n <= 1'b1;
        host_u.select();
        repeat (4) @(posedge clk);
        `CHK("flag converting", 1'b1, sdoLine)        // live flag
        waitIdle();
        `CHK("flag done", 1'b0, sdoLine)              // live flag
        for (int i = 0; i < 7; i++)
        begin
            waitIdle();
            curVal = vals[(i + 1) % 7];
            host_u.frame(32, codes[i], word);
            `CHK("word", expw[i], word)               // layout
            #2;
            `CHK("flag after fall 32", 1'b1, sdoLine) // next flag
            host_u.deselect();
            #1;
            `CHK("sdo released", 1'b0, sdoOe)         // float
            repeat (10) @(posedge clk);
            `CHK("busy after frame", 1'b1, busy)      // new conversion
            `CHK("rate", codes[i], oversamplingRatio) // rate code
            `CHK("ratio", logs[i], ratioLog2)         // decode
        end
        waitIdle();
        curVal = vals[6];
        host_u.frame(3, 5'h03, word);
        host_u.deselect();
        repeat (20) @(posedge clk);
        `CHK("early release", 1'b0, busy)             // no restart
        host_u.frame(8, 5'h03, word);
        `CHK("restart at top", 8'h20, word[31:24])    // held word
        host_u.deselect();
        repeat (6) @(posedge clk);
        `CHK("abort", 1'b1, busy)                     // abort starts
        clockSourceSelect <= 1'b1;
        waitIdle();
        `CHK("device clock enable", 1'b1, sckOe)      // clock pin
        sckPulses = 0;
        host_u.frame(32, 5'h1f, word);
        `CHK("device word", 32'h2abcdef1, word)       // device clock
        host_u.deselect();
        repeat (20) @(posedge clk);
        `CHK("pulses", 32, sckPulses)                 // burst length
        `CHK("busy after burst", 1'b1, busy)          // restart
        test_done();
    end
endmodule : tb_top
